// ===== logic/vectored_irq_sequencer.sv
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "irq_seq_defs.svh"
//
// Overview of operation
// [RULE1] Take only if flag, enable, gate all set
// [RULE2] Gate open sets, gate close clears gate
// [RULE3] Taking interrupt clears the gate
// [RULE4] Flags set regardless, held until cleared
// [RULE5] Flag cleared by entry or skip test
// [RULE6] Entry clears only serviced source flag
// [RULE7] Priority pin, timer one, timer two, conversion
// [RULE8] Vectors 0, 4, 6, C on page 1
// [RULE9] Conversion done is a request source
// [RULE10] Each flag pairs with enable and test
// [RULE11] Enable one blocks skip, zero permits skip
// [RULE12] Entry loads vector, pushes return address
// [RULE13] Entry copies context into save register
// [RULE14] Save register written only on entry
// [RULE15] Saved skip flag survives the interrupt
// [RULE16] 3-bit level pointer, readable into A
// [RULE17] Page above bit 7, offset wraps; the PC step here carries from the offset into the page field
// [RULE18] PC steps or loads target on jumps
// [RULE19] RAM pointer from group, file, nibble
// [RULE20] 10-bit words, 128-word pages, page 1 vectors
// [RULE21] Shared page call reaches page 2
// [RULE22] Table read returns low eight bits
// [RULE23] Entry 2 or 3 machine cycles later
// [RULE24] Gate open acts after next instruction
// [RULE25] Interrupt return pops and restores context
module vectored_irq_sequencer
  import irq_seq_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic pin_edge_in,
  input wire logic timer1_underflow_in,
  input wire logic timer2_underflow_in,
  input wire logic conv_done_in,
  input wire logic op_valid_in,
  input wire op_code_t op_code_in,
  input wire logic [1:0] op_src_in,
  input wire prog_addr_t op_target_in,
  input wire logic op_multi_in,
  input wire core_ctx_t ctx_in,
  input wire logic [9:0] rom_word_in,
  output prog_addr_t pc_out,
  output logic skip_out,
  output core_ctx_t ctx_restore_out,
  output logic ctx_load_out,
  output logic [3:0] level_out,
  output logic [7:0] table_data_out,
  output logic [3:0] port_bit_sel_out,
  output logic irq_entry_out
);
  // ********************************
  // State
  // ********************************
  logic [1:0] mc_cnt_reg; // Machine cycle divider
  logic mc_en; // One pulse per machine cycle
  logic [3:0] flag_reg; // Request flags
  logic [3:0] enable_reg; // Per-source enables
  logic gate_reg; // Master gate flag
  logic open_pend_reg; // Gate open waiting one instruction
  logic [1:0] lat_reg; // Entry latency count
  logic [2:0] sp_reg; // Stack level pointer
  prog_addr_t stack_mem [0:7]; // Return address stack
  core_ctx_t save_reg; // One-stage save register
  logic tbl_pend_reg; // Table data one cycle later
  logic [3:0] live; // Gated requests
  logic [1:0] win; // Winning source
  logic take; // Interrupt entry this cycle
  logic op_go; // Operation executes this cycle
  logic [3:0] skip_clr; // Flags cleared by skip tests
  logic [3:0] ent_clr; // Flag cleared by entry
  logic [3:0] ev; // Raw events
  logic bus_req; // Avalon access
  logic [6:0] vec_off; // Vector offset
  logic [2:0] sp_dn; // Pointer after pop

  // ********************************
  // Machine cycle divider
  // ********************************
  // System clock divided by three
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || mc_cnt_reg == `MC_DIV)
      mc_cnt_reg <= 2'h0;
    else
      mc_cnt_reg <= mc_cnt_reg + 2'h1;
  end
  assign mc_en = (mc_cnt_reg == `MC_DIV);
  // ********************************
  // Request gating and priority
  // ********************************
  assign ev = {conv_done_in, timer2_underflow_in, timer1_underflow_in, pin_edge_in}; // [RULE9] [RULE10]
  assign live = flag_reg & enable_reg & {4{gate_reg}}; // [RULE1]
  // Fixed priority, lowest index wins
  always_comb
  begin
    win = 2'h3;
    vec_off = `VEC_CONV; // [RULE8]
    if (live[`EN_PIN])
    begin
      win = 2'h0; // [RULE7]
      vec_off = `VEC_PIN;
    end
    else if (live[`EN_TMR1])
    begin
      win = 2'h1;
      vec_off = `VEC_TMR1;
    end
    else if (live[`EN_TMR2])
    begin
      win = 2'h2;
      vec_off = `VEC_TMR2;
    end
  end

  // ********************************
  // Entry latency
  // ********************************
  // Counts down the machine cycles left until entry once conditions are met
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || !(|live) || take)
      lat_reg <= 2'h0;
    else if (lat_reg == 2'h0)
      lat_reg <= op_multi_in ? `LAT_LONG : `LAT_SHORT; // [RULE23]
    else if (mc_en)
      lat_reg <= lat_reg - 2'h1;
  end
  assign take = (|live) && mc_en && (lat_reg == 2'h1); // [RULE23]
  // Entry wins over an instruction in the same cycle
  assign op_go = op_valid_in && !take;
  // ********************************
  // Request flags
  // ********************************
  always_comb
  begin
    skip_clr = 4'h0;
    ent_clr = 4'h0;
    if (op_go && op_code_in == OP_SKIP_TEST)
      skip_clr[op_src_in] = flag_reg[op_src_in] && !enable_reg[op_src_in]; // [RULE11]
    if (take)
      ent_clr[win] = 1'b1; // [RULE6]
  end
  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      flag_reg <= 4'h0;
    else
      flag_reg <= (flag_reg & ~(skip_clr | ent_clr)) | ev; // [RULE4] [RULE5]
  end
  // ********************************
  // Master gate
  // ********************************
  // Open takes hold after the following instruction
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      gate_reg <= 1'b0;
      open_pend_reg <= 1'b0;
    end
    else if (take)
    begin
      gate_reg <= 1'b0; // [RULE3]
      open_pend_reg <= 1'b0;
    end
    else if (op_go)
    begin
      if (op_code_in == OP_GATE_CLOSE)
      begin
        gate_reg <= 1'b0; // [RULE2]
        open_pend_reg <= 1'b0;
      end
      else if (op_code_in == OP_GATE_OPEN)
        open_pend_reg <= 1'b1; // [RULE24]
      else if (open_pend_reg)
      begin
        gate_reg <= 1'b1; // [RULE2] [RULE24]
        open_pend_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // Program counter and stack
  // ********************************
  assign sp_dn = sp_reg - 3'h1;
  // Pushes past eight levels overwrite the oldest entry
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pc_out <= `PC_RESET;
      sp_reg <= 3'h0;
    end
    else if (take)
    begin
      stack_mem[sp_reg] <= pc_out; // [RULE12]
      sp_reg <= sp_reg + 3'h1; // [RULE16]
      pc_out <= {`VEC_PAGE, vec_off}; // [RULE12] [RULE20]
    end
    else if (op_go)
    begin
      case (op_code_in)
        OP_BRANCH: pc_out <= op_target_in; // [RULE18]
        OP_CALL:
        begin
          stack_mem[sp_reg] <= pc_out + 12'h001;
          sp_reg <= sp_reg + 3'h1;
          pc_out <= op_target_in;
        end
        OP_SHARED_CALL:
        begin
          stack_mem[sp_reg] <= pc_out + 12'h001;
          sp_reg <= sp_reg + 3'h1;
          pc_out <= {`SHARED_PAGE, op_target_in.offset_field}; // [RULE21]
        end
        OP_RETURN, OP_RETURN_IRQ:
        begin
          pc_out <= stack_mem[sp_dn]; // [RULE25]
          sp_reg <= sp_dn;
        end
        default: pc_out <= pc_out + 12'h001; // [RULE17] [RULE18]
      endcase
    end
  end
  // ********************************
  // Save register and context
  // ********************************
  // Calls and table reads never touch it
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      save_reg <= '0;
    else if (take)
      save_reg <= ctx_in; // [RULE13] [RULE14] [RULE15]
  end
  // Restore on interrupt return
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctx_restore_out <= '0;
      ctx_load_out <= 1'b0;
    end
    else
    begin
      ctx_load_out <= op_go && op_code_in == OP_RETURN_IRQ; // [RULE25]
      if (op_go && op_code_in == OP_RETURN_IRQ)
        ctx_restore_out <= save_reg; // [RULE15] [RULE25]
    end
  end
  // ********************************
  // Operation results
  // ********************************
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      skip_out <= 1'b0;
      level_out <= 4'h0;
      irq_entry_out <= 1'b0;
      port_bit_sel_out <= 4'h0;
    end
    else
    begin
      skip_out <= |skip_clr; // [RULE11]
      irq_entry_out <= take;
      port_bit_sel_out <= ctx_in.nibble_select_reg; // [RULE19]
      if (op_go && op_code_in == OP_READ_LEVEL)
        level_out <= {1'b0, sp_reg}; // [RULE16]
    end
  end
  // Table word arrives a cycle after the read
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      tbl_pend_reg <= 1'b0;
      table_data_out <= 8'h00;
    end
    else
    begin
      tbl_pend_reg <= op_go && op_code_in == OP_TABLE_READ;
      if (tbl_pend_reg)
        table_data_out <= rom_word_in[7:0]; // [RULE22]
    end
  end
  // ********************************
  // Avalon slave
  // ********************************
  assign bus_req = avs_read_in || avs_write_in;
  // One wait cycle, then a one-cycle release
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
  end
  // Read data registered during the wait cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      avs_readdata_out <= 32'h0;
    else if (avs_read_in && avs_waitrequest_out)
    begin
      case (avs_address_in)
        `OFF_ENABLE: avs_readdata_out <= {28'h0, enable_reg};
        `OFF_STATUS: avs_readdata_out <= {23'h0, sp_reg, open_pend_reg, gate_reg, flag_reg};
        `OFF_PC: avs_readdata_out <= {20'h0, pc_out};
        `OFF_SAVE: avs_readdata_out <= {12'h0, save_reg};
        default: avs_readdata_out <= 32'h0; // Unmapped reads zero
      endcase
    end
  end
  // Enables written when the request completes
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      enable_reg <= 4'h0;
    else if (avs_write_in && !avs_waitrequest_out && avs_address_in == `OFF_ENABLE)
      enable_reg <= avs_writedata_in[3:0];
  end
  // ********************************
  // Assertions
  // ********************************
  AST_TAKE_NEEDS_ALL: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE1]
    take |-> (flag_reg[win] && enable_reg[win] && gate_reg))
    else $error("Entry without all conditions");
  AST_GATE_CLEAR: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE3]
    take |=> !gate_reg)
    else $error("Gate not cleared on entry");
  AST_CLOSE: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE2]
    (op_go && op_code_in == OP_GATE_CLOSE) |=> !gate_reg)
    else $error("Gate close failed");
  AST_FLAG_SET: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE4]
    ev[1] |=> flag_reg[1])
    else $error("Event lost");
  AST_VECTOR: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE8]
    (take && win == 2'h1) |=> pc_out == {`VEC_PAGE, `VEC_TMR1})
    else $error("Wrong vector");
  AST_PRIO: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE7]
    (take && live[0]) |-> win == 2'h0)
    else $error("Priority broken");
  AST_SAVE: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE14]
    !take |=> $stable(save_reg))
    else $error("Save register written outside entry");
  AST_PUSH: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE12]
    take |=> sp_reg == $past(sp_reg) + 3'h1)
    else $error("Stack not pushed");
  AST_LATENCY: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE23]
    ($rose(|live) && !op_multi_in) |-> ##[5:7] irq_entry_out)
    else $error("Entry latency out of range");
  AST_OPEN_DELAY: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE24]
    (op_go && op_code_in == OP_GATE_OPEN && !gate_reg) |=> !gate_reg)
    else $error("Gate opened too early");

endmodule // vectored_irq_sequencer

// ===== pkg/irq_seq_defs.svh
`ifndef IRQ_SEQ_DEFS_SVH
`define IRQ_SEQ_DEFS_SVH
// Register byte offsets
`define OFF_ENABLE 4'h0
`define OFF_STATUS 4'h4
`define OFF_PC 4'h8
`define OFF_SAVE 4'hc
// Enable bit positions
`define EN_PIN 0
`define EN_TMR1 1
`define EN_TMR2 2
`define EN_CONV 3
// Vector offsets on page 1
`define VEC_PIN 7'h00
`define VEC_TMR1 7'h04
`define VEC_TMR2 7'h06
`define VEC_CONV 7'h0c
`define VEC_PAGE 5'h01
`define SHARED_PAGE 5'h02
// Divider terminal count in system clocks, latencies in machine cycles, reset PC
`define MC_DIV 2'h2
`define LAT_SHORT 2'h2
`define LAT_LONG 2'h3
`define PC_RESET 12'h000
`endif

// ===== pkg/irq_seq_pkg.sv
package irq_seq_pkg;
  // Executed operation, one-hot
  typedef enum logic [10:0] {
    OP_STEP = 11'h001,
    OP_BRANCH = 11'h002,
    OP_CALL = 11'h004,
    OP_SHARED_CALL = 11'h008,
    OP_RETURN = 11'h010,
    OP_TABLE_READ = 11'h020,
    OP_GATE_OPEN = 11'h040,
    OP_GATE_CLOSE = 11'h080,
    OP_SKIP_TEST = 11'h100,
    OP_READ_LEVEL = 11'h200,
    OP_RETURN_IRQ = 11'h400
  } op_code_t;
  // Core context saved at entry
  typedef struct packed {
    logic [1:0] group_select_reg;
    logic [3:0] file_select_reg;
    logic [3:0] nibble_select_reg;
    logic carry;
    logic skip;
    logic [3:0] acc_a;
    logic [3:0] reg_b;
  } core_ctx_t;
  // Program counter split
  typedef struct packed {
    logic [4:0] page_field;
    logic [6:0] offset_field;
  } prog_addr_t;
endpackage

// ===== bench/event_src_model.sv
`timescale 1ns/1ps
// ****************************************
// Far-side event sources (pin, timers, converter)
// ****************************************
module event_src_model
(
  input wire logic clk_sys_in,
  input wire logic [3:0] fire_in,
  output logic [3:0] pulse_out
);
  // One-cycle event pulses, idle low between events
  always_ff @(posedge clk_sys_in)
  begin
    pulse_out <= fire_in;
  end
endmodule // event_src_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import irq_seq_pkg::*;
;
  // ****************************************
  // Stimulus signals
  // ****************************************
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] a_addr = 4'h0;
  logic a_rd = 1'b0;
  logic a_wr = 1'b0;
  logic [31:0] a_wd = 32'h0;
  logic [31:0] a_rdata;
  logic a_wait;
  logic [3:0] fire = 4'h0;
  logic [3:0] ev;
  logic op_valid = 1'b0;
  op_code_t op_code = OP_STEP;
  logic [1:0] op_src = 2'h0;
  prog_addr_t op_tgt = '0;
  logic op_multi = 1'b0;
  core_ctx_t ctx = '0;
  logic [9:0] rom = 10'h000;
  prog_addr_t pc;
  logic skip;
  logic entry;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int sk_exp = 0; // Skips still expected
  prog_addr_t exp_q[$]; // Expected entry addresses
  logic [6:0] vec[4] = '{7'h00, 7'h04, 7'h06, 7'h0c};
  logic [31:0] q;
  logic [3:0] m;
  core_ctx_t rctx; // Restored context
  core_ctx_t sv_ctx = '0; // Context seen at the last entry
  logic ld;
  logic [3:0] lvl;
  logic [7:0] tbl;
  logic [3:0] psel;
  int ld_exp = 0; // Restores still expected
  // Free clock, 4 ns period
  always #2 clk_sys_in = ~clk_sys_in;
  event_src_model src_u (.clk_sys_in(clk_sys_in), .fire_in(fire), .pulse_out(ev));
  vectored_irq_sequencer dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .avs_address_in(a_addr), .avs_read_in(a_rd), .avs_write_in(a_wr),
    .avs_writedata_in(a_wd), .avs_readdata_out(a_rdata), .avs_waitrequest_out(a_wait),
    .pin_edge_in(ev[0]), .timer1_underflow_in(ev[1]), .timer2_underflow_in(ev[2]),
    .conv_done_in(ev[3]), .op_valid_in(op_valid), .op_code_in(op_code),
    .op_src_in(op_src), .op_target_in(op_tgt), .op_multi_in(op_multi), .ctx_in(ctx),
    .rom_word_in(rom), .pc_out(pc), .skip_out(skip), .ctx_restore_out(rctx),
    .ctx_load_out(ld), .level_out(lvl), .table_data_out(tbl), .port_bit_sel_out(psel),
    .irq_entry_out(entry));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string s);
    miscompares++;
    $display("CHECK FAILED t=%0t %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp)
      fail(s);
  endtask
  // Avalon access; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    a_addr <= a;
    a_wd <= d;
    a_rd <= !wr;
    a_wr <= wr;
    do @(posedge clk_sys_in); while (a_wait !== 1'b0);
    q = a_rdata;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
  endtask
  // One executed instruction with fresh random core context
  task automatic do_op(input op_code_t c, input logic [1:0] s);
    @(posedge clk_sys_in);
    op_valid <= 1'b1;
    op_code <= c;
    op_src <= s;
    ctx <= core_ctx_t'(20'($urandom));
    op_tgt <= prog_addr_t'(12'($urandom));
    rom <= 10'($urandom);
    op_multi <= 1'($urandom);
    @(posedge clk_sys_in);
    op_valid <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_sys_in);
    fire <= v;
    @(posedge clk_sys_in);
    fire <= 4'h0;
  endtask
  // Opens the gate, then one more op so the open takes hold
  task automatic take();
    do_op(OP_GATE_OPEN, 2'h0);
    do_op(OP_STEP, 2'h0);
    for (int i = 0; i < 40 && exp_q.size() > 0; i++)
      @(posedge clk_sys_in);
    chk(exp_q.size(), 0, "entry missing");
  endtask
  // ****************************************
  // Output monitor; pulses checked in the cycle they stand
  // ****************************************
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail("timeout");
      print_verdict();
    end
    else if (!reset_in && entry === 1'b1)
    begin
      // Empty queue means an entry with the gate shut
      if (exp_q.size() == 0)
        fail("unexpected entry");
      else
      begin
        chk(pc, exp_q.pop_front(), "vector");
        sv_ctx <= ctx;
      end
    end
    // Restored context must be the one seen at the last entry
    if (!reset_in && ld === 1'b1)
    begin
      ld_exp--;
      chk(rctx, sv_ctx, "restore");
    end
    if (!reset_in && skip === 1'b1)
    begin
      n_checks++;
      if (sk_exp == 0)
        fail("unexpected skip");
      else
        sk_exp--;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(76));
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0, "enable reset");
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, 4'h0, 32'h0000000f);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000000f, "enable readback");
    // All four pending with gate shut; nothing may fire yet
    pulse(4'hf);
    repeat (20) @(posedge clk_sys_in);
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back({5'h01, vec[i]});
      take();
    end
    // Enables off: skip tests act and clear the flag
    bus(1'b1, 4'h0, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      pulse(4'h1 << s);
      sk_exp++;
      do_op(OP_SKIP_TEST, 2'(s));
      do_op(OP_SKIP_TEST, 2'(s));
    end
    repeat (4) @(posedge clk_sys_in);
    chk(sk_exp, 0, "skip missing");
    // Enables on: skip tests do nothing, flags stay pending
    bus(1'b1, 4'h0, 32'h0000000f);
    m = 4'($urandom_range(1, 15));
    pulse(m);
    for (int s = 0; s < 4; s++)
      do_op(OP_SKIP_TEST, 2'(s));
    for (int i = 3; i >= 0; i--)
      if (m[i])
        q = i;
    exp_q.push_back({5'h01, vec[q[1:0]]});
    take();
    // Close right after open: the open never takes hold
    pulse(4'hf);
    do_op(OP_GATE_OPEN, 2'h0);
    do_op(OP_GATE_CLOSE, 2'h0);
    do_op(OP_STEP, 2'h0);
    repeat (20) @(posedge clk_sys_in);
    // Five entries so far, none returned
    do_op(OP_READ_LEVEL, 2'h0);
    @(posedge clk_sys_in);
    chk(lvl, 32'h5, "level");
    chk(psel, ctx.nibble_select_reg, "port bit");
    do_op(OP_TABLE_READ, 2'h0);
    repeat (2) @(posedge clk_sys_in);
    chk(tbl, rom[7:0], "table");
    // Ops since the entry changed the context; the saved copy must not follow
    ld_exp++;
    do_op(OP_RETURN_IRQ, 2'h0);
    do_op(OP_READ_LEVEL, 2'h0);
    @(posedge clk_sys_in);
    chk(ld_exp, 0, "restore missing");
    chk(lvl, 32'h4, "level after return");
    do_op(OP_SHARED_CALL, 2'h0);
    @(posedge clk_sys_in);
    chk(pc, {5'h02, op_tgt.offset_field}, "shared call");
    print_verdict();
  end
endmodule // tb_top
